// *** hw/mcsa_core_regs.sv ***
`timescale 1ns/1ps
module mcsa_core_regs (
   input  wire logic                     clk_i,
   input  wire logic                     rst_n_i,
   // Register area port
   input  wire logic [7:0]               sfr_addr_i,
   input  wire logic                     sfr_we_i,
   input  wire logic                     sfr_re_i,
   input  wire logic [7:0]               sfr_wdata_i,
   output logic      [7:0]               sfr_rdata_o,
   output logic                          sfr_hit_o,
   // Core datapath updates
   input  wire mcsa_pkg::mcsa_core_op_t  core_op_i,
   // Internal RAM access
   input  wire mcsa_pkg::mcsa_ram_req_t  ram_req_i,
   output logic      [7:0]               ram_rdata_o,
   output logic                          ram_refused_o,
   // External space addressing
   input  wire mcsa_pkg::mcsa_xmem_req_t xmem_req_i,
   output mcsa_pkg::mcsa_xmem_bus_t      xmem_o,
   // State seen by the core
   output logic      [7:0]               acc_o,
   output logic      [7:0]               aux_o,
   output logic      [7:0]               psw_o,
   output logic      [7:0]               sp_o,
   output logic      [15:0]              dptr_o,
   output logic                          baud_double_o
);

   // Bank register address from bank number and register index
   function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] idx);
      bank_addr = {3'b000, bank, idx};
   endfunction

   // Byte holding a bit address of the bit area
   function automatic logic [7:0] bit_byte(input logic [6:0] bit_addr);
      bit_byte = mcsa_pkg::RAM_BIT_BASE | {4'h0, bit_addr[6:3]};
   endfunction

   function automatic logic sfr_write(input logic we, input logic [7:0] a, input logic [7:0] ofs);
      sfr_write = we && (a == ofs);
   endfunction

   logic [7:0]  acc_q, acc_d;
   logic [7:0]  aux_q, aux_d;
   logic [7:0]  sp_q, sp_d;
   logic [7:0]  page_q;
   logic [15:0] dptr0_q, dptr0_d;
   logic [15:0] dptr1_q, dptr1_d;
   logic        sel_q, sel_d;
   logic [7:0]  psc_q;
   logic        carry_q, nibble_q, wrap_q, user0_q, user1_q, parity_q;
   logic [1:0]  bank_q;
   logic [15:0] dptr_act_q;

   logic [7:0]  ram_addr;
   logic        ram_we;
   logic [7:0]  ram_mask;
   logic [7:0]  ram_wdata;
   logic        ram_bad;
   logic [7:0]  ram_rd_a;
   logic [7:0]  ptr_rd;
   logic [7:0]  ptr_addr;

   logic        xreq_q;
   logic        xwe_q;
   logic        xptr_used_q;
   mcsa_pkg::mcsa_xmem_kind_t xkind_q;

   // Internal RAM address generation
   always_comb begin
      ram_addr  = ram_req_i.addr;
      ram_mask  = 8'hff;
      ram_wdata = ram_req_i.wdata;
      ram_bad   = 1'b0;
      case (ram_req_i.mode)
         mcsa_pkg::MCSA_RAM_DIRECT: begin
            // Upper half only by indirect; direct reach above it is the register area
            ram_bad = ram_req_i.addr >= mcsa_pkg::RAM_UPPER_BASE;
         end
         mcsa_pkg::MCSA_RAM_INDIRECT: begin
            ram_addr = ram_req_i.addr;
         end
         mcsa_pkg::MCSA_RAM_REG: begin
            ram_addr = bank_addr(bank_q, ram_req_i.addr[2:0]);
         end
         mcsa_pkg::MCSA_RAM_BIT: begin
            ram_bad   = ram_req_i.addr[7];
            ram_addr  = bit_byte(ram_req_i.addr[6:0]);
            ram_mask  = 8'h01 << ram_req_i.addr[2:0];
            ram_wdata = {8{ram_req_i.wdata[0]}};
         end
         mcsa_pkg::MCSA_RAM_PUSH: begin
            ram_addr = sp_q + 8'h01;
         end
         mcsa_pkg::MCSA_RAM_POP: begin
            ram_addr = sp_q;
         end
         default: begin
            ram_bad = 1'b1;
         end
      endcase
   end

   assign ram_we   = ram_req_i.en && !ram_bad &&
                     (ram_req_i.we || (ram_req_i.mode == mcsa_pkg::MCSA_RAM_PUSH)) &&
                     (ram_req_i.mode != mcsa_pkg::MCSA_RAM_POP);
   assign ptr_addr = bank_addr(bank_q, {2'b00, xmem_req_i.ptr_sel});

   mcsa_internal_data_ram u_internal_data_ram (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .addr_a_i  (ram_addr),
      .we_a_i    (ram_we),
      .mask_a_i  (ram_mask),
      .wdata_a_i (ram_wdata),
      .rdata_a_o (ram_rd_a),
      .addr_b_i  (ptr_addr),
      .rdata_b_o (ptr_rd)
   );

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ram_refused_o <= 1'b0;
      end else begin
         ram_refused_o <= ram_req_i.en && ram_bad;
      end
   end

   assign ram_rdata_o = ram_rd_a;

   // Next values: core datapath takes priority over register area writes
   always_comb begin
      acc_d = acc_q;
      if (core_op_i.acc_we) begin
         acc_d = core_op_i.acc_wdata;
      end else if (sfr_write(sfr_we_i, sfr_addr_i, mcsa_pkg::OFS_ACCUM)) begin
         acc_d = sfr_wdata_i;
      end
   end

   always_comb begin
      aux_d = aux_q;
      if (core_op_i.aux_we) begin
         aux_d = core_op_i.aux_wdata;
      end else if (sfr_write(sfr_we_i, sfr_addr_i, mcsa_pkg::OFS_MUL_AUX)) begin
         aux_d = sfr_wdata_i;
      end
   end

   always_comb begin
      sp_d = sp_q;
      if (ram_req_i.en && ram_req_i.mode == mcsa_pkg::MCSA_RAM_PUSH) begin
         sp_d = sp_q + 8'h01;
      end else if (ram_req_i.en && ram_req_i.mode == mcsa_pkg::MCSA_RAM_POP) begin
         sp_d = sp_q - 8'h01;
      end else if (sfr_write(sfr_we_i, sfr_addr_i, mcsa_pkg::OFS_STACK_TOP)) begin
         sp_d = sfr_wdata_i;
      end
   end

   always_comb begin
      sel_d = sel_q;
      if (sfr_write(sfr_we_i, sfr_addr_i, mcsa_pkg::OFS_PTR_SELECT)) begin
         sel_d = sfr_wdata_i[mcsa_pkg::SEL_BIT];
      end
   end

   // 16-bit operations act on the pointer selected now
   always_comb begin
      dptr0_d = dptr0_q;
      dptr1_d = dptr1_q;
      if (core_op_i.dptr_we) begin
         if (sel_q) begin
            dptr1_d = core_op_i.dptr_wdata;
         end else begin
            dptr0_d = core_op_i.dptr_wdata;
         end
      end else if (core_op_i.dptr_inc) begin
         if (sel_q) begin
            dptr1_d = dptr1_q + 16'h0001;
         end else begin
            dptr0_d = dptr0_q + 16'h0001;
         end
      end else if (sfr_we_i) begin
         if (sfr_addr_i == mcsa_pkg::OFS_DPTR0_LOW) begin
            dptr0_d[7:0] = sfr_wdata_i;
         end else if (sfr_addr_i == mcsa_pkg::OFS_DPTR0_HIGH) begin
            dptr0_d[15:8] = sfr_wdata_i;
         end else if (sfr_addr_i == mcsa_pkg::OFS_DPTR1_LOW) begin
            dptr1_d[7:0] = sfr_wdata_i;
         end else if (sfr_addr_i == mcsa_pkg::OFS_DPTR1_HIGH) begin
            dptr1_d[15:8] = sfr_wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_q    <= mcsa_pkg::RST_BYTE;
         aux_q    <= mcsa_pkg::RST_BYTE;
         parity_q <= 1'b0;
      end else begin
         acc_q    <= acc_d;
         aux_q    <= aux_d;
         // Follows the accumulator in the same edge, never software
         parity_q <= ^acc_d;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sp_q <= mcsa_pkg::RST_STACK_TOP;
      end else begin
         sp_q <= sp_d;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dptr0_q    <= {mcsa_pkg::RST_BYTE, mcsa_pkg::RST_BYTE};
         dptr1_q    <= {mcsa_pkg::RST_BYTE, mcsa_pkg::RST_BYTE};
         sel_q      <= 1'b0;
         dptr_act_q <= {mcsa_pkg::RST_BYTE, mcsa_pkg::RST_BYTE};
      end else begin
         dptr0_q    <= dptr0_d;
         dptr1_q    <= dptr1_d;
         sel_q      <= sel_d;
         dptr_act_q <= sel_d ? dptr1_d : dptr0_d;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         page_q <= mcsa_pkg::RST_BYTE;
      end else if (sfr_write(sfr_we_i, sfr_addr_i, mcsa_pkg::OFS_PAGE_BASE)) begin
         page_q <= sfr_wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         psc_q <= mcsa_pkg::RST_BYTE;
      end else if (sfr_write(sfr_we_i, sfr_addr_i, mcsa_pkg::OFS_PWR_SERIAL)) begin
         // Low two bits never stored, whatever software writes
         psc_q <= sfr_wdata_i & mcsa_pkg::PSC_WR_MASK;
      end
   end

   // Status word: hardware flag updates beat software writes in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         carry_q  <= 1'b0;
         nibble_q <= 1'b0;
         wrap_q   <= 1'b0;
         user0_q  <= 1'b0;
         user1_q  <= 1'b0;
         bank_q   <= 2'b00;
      end else begin
         if (core_op_i.carry_we) begin
            carry_q <= core_op_i.carry_flag;
         end else if (sfr_write(sfr_we_i, sfr_addr_i, mcsa_pkg::OFS_STATUS)) begin
            carry_q <= sfr_wdata_i[mcsa_pkg::PSW_CARRY];
         end
         if (core_op_i.nibble_we) begin
            nibble_q <= core_op_i.nibble_carry;
         end else if (sfr_write(sfr_we_i, sfr_addr_i, mcsa_pkg::OFS_STATUS)) begin
            nibble_q <= sfr_wdata_i[mcsa_pkg::PSW_NIBBLE];
         end
         if (core_op_i.wrap_we) begin
            wrap_q <= core_op_i.signed_wrap_flag;
         end else if (sfr_write(sfr_we_i, sfr_addr_i, mcsa_pkg::OFS_STATUS)) begin
            wrap_q <= sfr_wdata_i[mcsa_pkg::PSW_WRAP];
         end
         if (sfr_write(sfr_we_i, sfr_addr_i, mcsa_pkg::OFS_STATUS)) begin
            user0_q <= sfr_wdata_i[mcsa_pkg::PSW_USER0];
            user1_q <= sfr_wdata_i[mcsa_pkg::PSW_USER1];
            bank_q  <= sfr_wdata_i[mcsa_pkg::PSW_BANK_HI:mcsa_pkg::PSW_BANK_LO];
         end
      end
   end

   // Register area read, one cycle after the strobe
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sfr_rdata_o <= 8'h00;
         sfr_hit_o   <= 1'b0;
      end else if (!sfr_re_i) begin
         sfr_rdata_o <= 8'h00;
         sfr_hit_o   <= 1'b0;
      end else begin
         sfr_hit_o <= 1'b1;
         if (sfr_addr_i == mcsa_pkg::OFS_ACCUM) begin
            sfr_rdata_o <= acc_q;
         end else if (sfr_addr_i == mcsa_pkg::OFS_MUL_AUX) begin
            sfr_rdata_o <= aux_q;
         end else if (sfr_addr_i == mcsa_pkg::OFS_STATUS) begin
            sfr_rdata_o <= {carry_q, nibble_q, user0_q, bank_q, wrap_q, user1_q, parity_q};
         end else if (sfr_addr_i == mcsa_pkg::OFS_STACK_TOP) begin
            sfr_rdata_o <= sp_q;
         end else if (sfr_addr_i == mcsa_pkg::OFS_DPTR0_LOW) begin
            sfr_rdata_o <= dptr0_q[7:0];
         end else if (sfr_addr_i == mcsa_pkg::OFS_DPTR0_HIGH) begin
            sfr_rdata_o <= dptr0_q[15:8];
         end else if (sfr_addr_i == mcsa_pkg::OFS_DPTR1_LOW) begin
            sfr_rdata_o <= dptr1_q[7:0];
         end else if (sfr_addr_i == mcsa_pkg::OFS_DPTR1_HIGH) begin
            sfr_rdata_o <= dptr1_q[15:8];
         end else if (sfr_addr_i == mcsa_pkg::OFS_PTR_SELECT) begin
            sfr_rdata_o <= {7'h00, sel_q};
         end else if (sfr_addr_i == mcsa_pkg::OFS_PWR_SERIAL) begin
            sfr_rdata_o <= psc_q & mcsa_pkg::PSC_WR_MASK;
         end else if (sfr_addr_i == mcsa_pkg::OFS_PAGE_BASE) begin
            sfr_rdata_o <= page_q;
         end else begin
            sfr_rdata_o <= 8'h00;
            sfr_hit_o   <= 1'b0;
         end
      end
   end

   // External address: request staged one cycle so R0/R1 can be fetched
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xreq_q      <= 1'b0;
         xwe_q       <= 1'b0;
         xptr_used_q <= 1'b0;
         xkind_q     <= mcsa_pkg::MCSA_X_DPTR;
      end else begin
         xreq_q      <= xmem_req_i.en;
         xwe_q       <= xmem_req_i.we;
         xptr_used_q <= xmem_req_i.kind == mcsa_pkg::MCSA_X_PAGED;
         xkind_q     <= xmem_req_i.kind;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xmem_o <= '0;
      end else begin
         xmem_o.valid <= xreq_q;
         xmem_o.we    <= xreq_q && xwe_q;
         if (xptr_used_q) begin
            xmem_o.addr       <= {page_q, ptr_rd};
            xmem_o.code_space <= psc_q[mcsa_pkg::PSC_CODE_MV];
         end else if (xkind_q == mcsa_pkg::MCSA_X_DPTR_ACC) begin
            // Code reads and computed jumps always go to code space
            xmem_o.addr       <= dptr_act_q + {8'h00, acc_q};
            xmem_o.code_space <= 1'b1;
         end else begin
            xmem_o.addr       <= dptr_act_q;
            xmem_o.code_space <= psc_q[mcsa_pkg::PSC_CODE_MV];
         end
      end
   end

   assign acc_o         = acc_q;
   assign aux_o         = aux_q;
   assign sp_o          = sp_q;
   assign dptr_o        = dptr_act_q;
   assign psw_o         = {carry_q, nibble_q, user0_q, bank_q, wrap_q, user1_q, parity_q};
   assign baud_double_o = psc_q[mcsa_pkg::PSC_BAUD_DBL];

endmodule

// *** hw/mcsa_internal_data_ram.sv ***
`timescale 1ns/1ps
module mcsa_internal_data_ram (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] addr_a_i,
   input  wire logic       we_a_i,
   input  wire logic [7:0] mask_a_i,
   input  wire logic [7:0] wdata_a_i,
   output logic      [7:0] rdata_a_o,
   input  wire logic [7:0] addr_b_i,
   output logic      [7:0] rdata_b_o
);

   logic [7:0] mem_q [mcsa_pkg::RAM_DEPTH];

   // Masked write lets bit operations touch one bit only
   always_ff @(posedge clk_i) begin
      if (we_a_i) begin
         mem_q[addr_a_i] <= (mem_q[addr_a_i] & ~mask_a_i) | (wdata_a_i & mask_a_i);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_a_o <= 8'h00;
         rdata_b_o <= 8'h00;
      end else begin
         rdata_a_o <= mem_q[addr_a_i];
         rdata_b_o <= mem_q[addr_b_i];
      end
   end

endmodule

// *** hw/mcsa_pkg.sv ***
// Summary of operation
// - Separate 64 kB code and data spaces, 256-byte internal RAM, 128-byte register area.
// - Low 128 RAM bytes hold banks and bit area; upper half indirect only.
// - Lowest 32 bytes are four banks of R0-R7 chosen by two status bits.
// - Bytes 0x20-0x2F are bit addressable as bit addresses 0x00-0x7F.
// - Paged data address is page base in bits 15:8, R0/R1 in 7:0.
// - Page base register is 8-bit read/write, resets to 0x00.
// - Status bit 0 is accumulator odd parity, hardware only.
// - Status bit 7 is carry and Boolean bit accumulator.
// - Status bit 6 is carry out of accumulator bit 3.
// - Status bit 2 is signed overflow of the accumulator.
// - Status bits 4-3 select bank at 0x00, 0x08, 0x10 or 0x18.
// - Stack pointer pre-increments on push, post-decrements on pop.
// - First data pointer is two bytes and one 16-bit address.
// - Second data pointer, two bytes, same addressing roles.
// - Pointer select bit 0 picks active data pointer; bits 7:1 unused.
// - Power/serial control bit 4 steers external moves to code space.
// - Power/serial control bits 1 and 0 read 0; software writes 0.
// - Power/serial control bit 7 doubles baud; bits 6,5,3,2 storage.
// - Auxiliary register feeds and takes multiply/divide operands, else scratch.
// - Accumulator is 8-bit operand and result register.
// - Status bits 5 and 1 are plain user flags.
package mcsa_pkg;

   // Register area offsets
   localparam logic [7:0] OFS_STACK_TOP  = 8'h81;
   localparam logic [7:0] OFS_DPTR0_LOW  = 8'h82;
   localparam logic [7:0] OFS_DPTR0_HIGH = 8'h83;
   localparam logic [7:0] OFS_DPTR1_LOW  = 8'h84;
   localparam logic [7:0] OFS_DPTR1_HIGH = 8'h85;
   localparam logic [7:0] OFS_PWR_SERIAL = 8'h87;
   localparam logic [7:0] OFS_PTR_SELECT = 8'h92;
   localparam logic [7:0] OFS_PAGE_BASE  = 8'hc9;
   localparam logic [7:0] OFS_STATUS     = 8'hd0;
   localparam logic [7:0] OFS_ACCUM      = 8'he0;
   localparam logic [7:0] OFS_MUL_AUX    = 8'hf0;

   // Reset values
   localparam logic [7:0] RST_STACK_TOP  = 8'h07;
   localparam logic [7:0] RST_BYTE       = 8'h00;

   // Status word fields
   localparam int PSW_CARRY    = 7;
   localparam int PSW_NIBBLE   = 6;
   localparam int PSW_USER0    = 5;
   localparam int PSW_BANK_HI  = 4;
   localparam int PSW_BANK_LO  = 3;
   localparam int PSW_WRAP     = 2;
   localparam int PSW_USER1    = 1;
   localparam int PSW_PARITY   = 0;

   // Power/serial control and pointer select fields
   localparam int         PSC_BAUD_DBL = 7;
   localparam int         PSC_CODE_MV  = 4;
   localparam logic [7:0] PSC_WR_MASK  = 8'hfc;
   localparam int         SEL_BIT      = 0;

   // Internal RAM layout
   localparam logic [7:0] RAM_BIT_BASE   = 8'h20;
   localparam logic [7:0] RAM_UPPER_BASE = 8'h80;
   localparam int         RAM_DEPTH      = 256;

   typedef enum logic [2:0] {
      MCSA_RAM_DIRECT,
      MCSA_RAM_INDIRECT,
      MCSA_RAM_REG,
      MCSA_RAM_BIT,
      MCSA_RAM_PUSH,
      MCSA_RAM_POP
   } mcsa_ram_mode_t;

   typedef struct packed {
      logic           en;
      logic           we;
      mcsa_ram_mode_t mode;
      logic [7:0]     addr;
      logic [7:0]     wdata;
   } mcsa_ram_req_t;

   typedef struct packed {
      logic        acc_we;
      logic [7:0]  acc_wdata;
      logic        aux_we;
      logic [7:0]  aux_wdata;
      logic        carry_we;
      logic        carry_flag;
      logic        nibble_we;
      logic        nibble_carry;
      logic        wrap_we;
      logic        signed_wrap_flag;
      logic        dptr_inc;
      logic        dptr_we;
      logic [15:0] dptr_wdata;
   } mcsa_core_op_t;

   typedef enum logic [1:0] {
      MCSA_X_PAGED,
      MCSA_X_DPTR,
      MCSA_X_DPTR_ACC
   } mcsa_xmem_kind_t;

   typedef struct packed {
      logic            en;
      logic            we;
      mcsa_xmem_kind_t kind;
      logic            ptr_sel;
   } mcsa_xmem_req_t;

   typedef struct packed {
      logic        valid;
      logic        we;
      logic        code_space;
      logic [15:0] addr;
   } mcsa_xmem_bus_t;

endpackage

// *** tb/mcsa_core_regs_chk.sv ***
`timescale 1ns/1ps
module mcsa_core_regs_chk (
   input wire logic                     clk_i,
   input wire logic                     rst_n_i,
   input wire logic [7:0]               sfr_addr_i,
   input wire logic                     sfr_we_i,
   input wire logic                     sfr_re_i,
   input wire logic [7:0]               sfr_wdata_i,
   input wire logic [7:0]               sfr_rdata_o,
   input wire logic                     sfr_hit_o,
   input wire mcsa_pkg::mcsa_ram_req_t  ram_req_i,
   input wire mcsa_pkg::mcsa_xmem_req_t xmem_req_i,
   input wire mcsa_pkg::mcsa_xmem_bus_t xmem_o,
   input wire logic [7:0]               acc_o,
   input wire logic [7:0]               psw_o,
   input wire logic [7:0]               sp_o,
   input wire logic                     baud_double_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_rd(logic [7:0] a);
      sfr_re_i && sfr_addr_i == a;
   endsequence
   sequence s_op(mcsa_pkg::mcsa_ram_mode_t m);
      ram_req_i.en && ram_req_i.mode == m;
   endsequence
   a_parity_tracks: assert property (psw_o[0] == ^acc_o)
      else $error("parity bit wrong");
   a_acc_readback: assert property (s_rd(mcsa_pkg::OFS_ACCUM) |=> sfr_hit_o && sfr_rdata_o == $past(acc_o))
      else $error("accumulator read wrong");
   a_push_bumps_sp: assert property (s_op(mcsa_pkg::MCSA_RAM_PUSH) |=> sp_o == $past(sp_o) + 8'h01)
      else $error("push did not raise stack pointer");
   a_pop_drops_sp: assert property (s_op(mcsa_pkg::MCSA_RAM_POP) |=> sp_o == $past(sp_o) - 8'h01)
      else $error("pop did not lower stack pointer");
   a_power_serial_ctrl_low_zero: assert property (s_rd(mcsa_pkg::OFS_PWR_SERIAL) |=> sfr_rdata_o[1:0] == 2'b00)
      else $error("power control low bits not zero");
   a_select_top_zero: assert property (s_rd(mcsa_pkg::OFS_PTR_SELECT) |=> sfr_rdata_o[7:1] == 7'h00)
      else $error("pointer select upper bits not zero");
   a_baud_follows: assert property (sfr_we_i && sfr_addr_i == mcsa_pkg::OFS_PWR_SERIAL
      |=> {baud_double_o, 7'h00} == ($past(sfr_wdata_i) & 8'h80))
      else $error("baud doubler not stored");
   a_xmem_latency: assert property (xmem_req_i.en |-> ##2 xmem_o.valid)
      else $error("external address not issued in two cycles");
   a_code_for_acc: assert property (xmem_req_i.en && xmem_req_i.kind == mcsa_pkg::MCSA_X_DPTR_ACC
      |-> ##2 xmem_o.code_space)
      else $error("indexed pointer move not in code space");
endmodule

// *** tb/test_mcsa_core_regs.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module test_mcsa_core_regs;
   logic                     clk_i;
   logic                     rst_n_i;
   logic [7:0]               sfr_addr_i;
   logic                     sfr_we_i;
   logic                     sfr_re_i;
   logic [7:0]               sfr_wdata_i;
   logic [7:0]               sfr_rdata_o;
   logic                     sfr_hit_o;
   mcsa_pkg::mcsa_core_op_t  core_op_i;
   mcsa_pkg::mcsa_ram_req_t  ram_req_i;
   logic [7:0]               ram_rdata_o;
   logic                     ram_refused_o;
   mcsa_pkg::mcsa_xmem_req_t xmem_req_i;
   mcsa_pkg::mcsa_xmem_bus_t xmem_o;
   logic [7:0]               acc_o, aux_o, psw_o, sp_o, rd, e;
   logic [15:0]              dptr_o;
   logic                     baud_double_o;
   int                       fail_count;
   int                       comparisons;
   logic [7:0]               ofs [11];
   logic [7:0]               wv [11];
   mcsa_core_regs mcsa_core_regs_i (
      .clk_i, .rst_n_i, .sfr_addr_i, .sfr_we_i, .sfr_re_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o,
      .core_op_i, .ram_req_i, .ram_rdata_o, .ram_refused_o, .xmem_req_i, .xmem_o,
      .acc_o, .aux_o, .psw_o, .sp_o, .dptr_o, .baud_double_o
   );
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // Shared release edge, so a strobe is never set and cleared in one step
   task automatic fin();
      @(posedge clk_i);
      sfr_we_i   <= 1'b0;
      sfr_re_i   <= 1'b0;
      ram_req_i  <= '0;
      xmem_req_i <= '0;
      core_op_i  <= '0;
      #1;
   endtask
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_we_i    <= 1'b1;
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      fin();
   endtask
   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] x, input logic h);
      @(posedge clk_i);
      sfr_re_i   <= 1'b1;
      sfr_addr_i <= a;
      fin();
      `CHK("sfr_rdata_o", x, sfr_rdata_o)
      `CHK("sfr_hit_o", h, sfr_hit_o)
   endtask
   task automatic ram(input mcsa_pkg::mcsa_ram_mode_t m, input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      ram_req_i <= '{en: 1'b1, we: w, mode: m, addr: a, wdata: d};
      fin();
      rd = ram_rdata_o;
   endtask
   task automatic xm(input mcsa_pkg::mcsa_xmem_kind_t k, input logic s, input logic [15:0] a, input logic c);
      int n;
      @(posedge clk_i);
      xmem_req_i <= '{en: 1'b1, we: s, kind: k, ptr_sel: s};
      fin();
      for (n = 0; n < 4 && xmem_o.valid !== 1'b1; n++) begin
         @(posedge clk_i);
         #1;
      end
      `CHK("xmem_o.addr", a, xmem_o.addr)
      `CHK("xmem_o.code_space", c, xmem_o.code_space)
      `CHK("xmem_o.we", s, xmem_o.we)
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Sequence needs some 160 cycles; 25 times that before calling it a hang
   initial begin
      #16000;
      fail_count++;
      $display("Error watchdog expected finish seen hang");
      complete_run();
   end
   initial begin
      rst_n_i     = 1'b0;
      sfr_addr_i  = '0;
      sfr_we_i    = 1'b0;
      sfr_re_i    = 1'b0;
      sfr_wdata_i = '0;
      core_op_i   = '0;
      ram_req_i   = '0;
      xmem_req_i  = '0;
      fail_count  = 0;
      comparisons = 0;
      ofs = '{mcsa_pkg::OFS_STACK_TOP, mcsa_pkg::OFS_DPTR0_LOW, mcsa_pkg::OFS_DPTR0_HIGH, mcsa_pkg::OFS_DPTR1_LOW,
              mcsa_pkg::OFS_DPTR1_HIGH, mcsa_pkg::OFS_PWR_SERIAL, mcsa_pkg::OFS_PTR_SELECT,
              mcsa_pkg::OFS_PAGE_BASE, mcsa_pkg::OFS_STATUS, mcsa_pkg::OFS_ACCUM, mcsa_pkg::OFS_MUL_AUX};
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         sfr_rd(ofs[i], (i == 0) ? 8'h07 : 8'h00, 1'b1);
         wv[i] = 8'h5a + 8'h11 * i[7:0];
      end
      $display("reset values done");
      // Low control bits kept clear by software; parity write attempted
      wv[5] = wv[5] & 8'hfc;
      wv[8] = wv[8] | 8'h01;
      for (int i = 0; i < 11; i++) begin
         sfr_wr(ofs[i], wv[i]);
      end
      for (int i = 0; i < 11; i++) begin
         e = (i == 6) ? {7'h00, wv[6][0]} : (i == 8) ? {wv[8][7:1], ^wv[9]} : wv[i];
         sfr_rd(ofs[i], e, 1'b1);
      end
      sfr_rd(8'h86, 8'h00, 1'b0);
      `CHK("baud_double_o", 1'b1, baud_double_o)
      `CHK("aux_o", wv[10], aux_o)
      $display("register access done");
      for (int b = 0; b < 4; b++) begin
         sfr_wr(mcsa_pkg::OFS_STATUS, 8'(b) << 3);
         ram(mcsa_pkg::MCSA_RAM_REG, 1'b1, 8'h02, 8'h40 + 8'(b));
      end
      for (int b = 0; b < 4; b++) begin
         ram(mcsa_pkg::MCSA_RAM_DIRECT, 1'b0, 8'(b * 8 + 2), 8'h00);
         `CHK("bank byte", 8'h40 + 8'(b), rd)
      end
      $display("banks done");
      ram(mcsa_pkg::MCSA_RAM_DIRECT, 1'b1, 8'h22, 8'h00);
      ram(mcsa_pkg::MCSA_RAM_BIT, 1'b1, 8'h13, 8'h01);
      ram(mcsa_pkg::MCSA_RAM_DIRECT, 1'b0, 8'h22, 8'h00);
      `CHK("bit byte", 8'h08, rd)
      ram(mcsa_pkg::MCSA_RAM_BIT, 1'b1, 8'h80, 8'h01);
      `CHK("ram_refused_o", 1'b1, ram_refused_o)
      ram(mcsa_pkg::MCSA_RAM_DIRECT, 1'b1, 8'h90, 8'h66);
      `CHK("ram_refused_o", 1'b1, ram_refused_o)
      ram(mcsa_pkg::MCSA_RAM_INDIRECT, 1'b1, 8'h90, 8'h77);
      ram(mcsa_pkg::MCSA_RAM_INDIRECT, 1'b0, 8'h90, 8'h00);
      `CHK("upper byte", 8'h77, rd)
      $display("bit area done");
      sfr_wr(mcsa_pkg::OFS_STACK_TOP, 8'h07);
      ram(mcsa_pkg::MCSA_RAM_PUSH, 1'b1, 8'h00, 8'h11);
      ram(mcsa_pkg::MCSA_RAM_PUSH, 1'b1, 8'h00, 8'h22);
      `CHK("sp_o", 8'h09, sp_o)
      ram(mcsa_pkg::MCSA_RAM_INDIRECT, 1'b0, 8'h08, 8'h00);
      `CHK("first push", 8'h11, rd)
      ram(mcsa_pkg::MCSA_RAM_POP, 1'b0, 8'h00, 8'h00);
      `CHK("pop", 8'h22, rd)
      `CHK("sp_o", 8'h08, sp_o)
      $display("stack done");
      sfr_wr(mcsa_pkg::OFS_PWR_SERIAL, 8'h00);
      sfr_wr(mcsa_pkg::OFS_PTR_SELECT, 8'h00);
      `CHK("dptr_o", {wv[2], wv[1]}, dptr_o)
      xm(mcsa_pkg::MCSA_X_DPTR, 1'b0, {wv[2], wv[1]}, 1'b0);
      sfr_wr(mcsa_pkg::OFS_PTR_SELECT, 8'h01);
      sfr_wr(mcsa_pkg::OFS_PWR_SERIAL, 8'h10);
      xm(mcsa_pkg::MCSA_X_DPTR, 1'b0, {wv[4], wv[3]}, 1'b1);
      xm(mcsa_pkg::MCSA_X_DPTR_ACC, 1'b0, {wv[4], wv[3]} + 16'(wv[9]), 1'b1);
      @(posedge clk_i);
      core_op_i <= '{dptr_inc: 1'b1, default: '0};
      fin();
      `CHK("dptr_o", {wv[4], wv[3]} + 16'h0001, dptr_o)
      sfr_wr(mcsa_pkg::OFS_PWR_SERIAL, 8'h00);
      sfr_wr(mcsa_pkg::OFS_STATUS, 8'h00);
      ram(mcsa_pkg::MCSA_RAM_REG, 1'b1, 8'h01, 8'h56);
      xm(mcsa_pkg::MCSA_X_PAGED, 1'b1, {wv[7], 8'h56}, 1'b0);
      $display("pointers done");
      @(posedge clk_i);
      core_op_i <= '{carry_we: 1'b1, carry_flag: 1'b1, nibble_we: 1'b1, nibble_carry: 1'b1, wrap_we: 1'b1,
                     dptr_we: 1'b1, dptr_inc: 1'b1, dptr_wdata: 16'hc35a,
                     signed_wrap_flag: 1'b1, aux_we: 1'b1, aux_wdata: 8'h3c, default: '0};
      fin();
      `CHK("psw_o", {2'b11, 3'b000, 1'b1, 1'b0, ^wv[9]}, psw_o)
      `CHK("aux_o", 8'h3c, aux_o)
      `CHK("dptr_o", 16'hc35a, dptr_o)
      // Core result and software write land on the accumulator at one edge
      @(posedge clk_i);
      core_op_i   <= '{acc_we: 1'b1, acc_wdata: 8'h07, default: '0};
      sfr_we_i    <= 1'b1;
      sfr_addr_i  <= mcsa_pkg::OFS_ACCUM;
      sfr_wdata_i <= 8'h55;
      fin();
      `CHK("acc_o", 8'h07, acc_o)
      `CHK("parity", 1'b1, psw_o[0])
      $display("core updates done");
      complete_run();
   end
endmodule
bind mcsa_core_regs mcsa_core_regs_chk mcsa_core_regs_chk_i (.clk_i, .rst_n_i, .sfr_addr_i, .sfr_we_i, .sfr_re_i,
   .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .ram_req_i, .xmem_req_i, .xmem_o, .acc_o, .psw_o, .sp_o, .baud_double_o);
